/* File: common/ethst_regs.svh */
// register offsets, field positions, reset values and counts for the status and statistics block
`ifndef ETHST_REGS_SVH
`define ETHST_REGS_SVH

`define ETHST_OFF_CON1   8'h00
`define ETHST_OFF_IRQ    8'h10
`define ETHST_OFF_STAT   8'h20
`define ETHST_OFF_RXOVF  8'h30
`define ETHST_OFF_TXOK   8'h40
`define ETHST_OFF_SCOL   8'h50

`define ETHST_BIT_ON     15
`define ETHST_BIT_BUSY   7
`define ETHST_BIT_TXACT  6
`define ETHST_BIT_RXACT  5
`define ETHST_BIT_OVF    0

`define ETHST_CNT_RST    16'h0000
`define ETHST_CNT_ONE    16'h0001
`define ETHST_ONE_COLL   4'h1
`define ETHST_ZERO16     16'h0000

`endif

/* File: common/ethst_pkg.sv */
// types shared by the status and statistics block
package ethst_pkg;

    typedef enum logic [1:0] {
        ALIAS_WRITE,
        ALIAS_CLR,
        ALIAS_SET,
        ALIAS_INV
    } ethst_alias_t;

    typedef enum logic {
        SLV_IDLE,
        SLV_ACK
    } ethst_slv_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } ethst_bus_t;

    typedef struct packed {
        logic         inc;
        logic         wr;
        ethst_alias_t mode;
        logic [15:0]  wdata;
        logic [15:0]  wmask;
        logic         rdClr;
        logic [15:0]  rdVal;
    } ethst_cnt_cmd_t;

    function automatic logic [15:0] ethst_alias_apply(input logic [15:0] old, input logic [15:0] wdata,
                                                      input logic [15:0] mask, input ethst_alias_t mode);
        logic [15:0] bits;
        bits = wdata & mask;
        case (mode)
            ALIAS_WRITE: return (old & ~mask) | bits;
            ALIAS_CLR:   return old & ~bits;
            ALIAS_SET:   return old | bits;
            ALIAS_INV:   return old ^ bits;
            default:     return old;
        endcase
    endfunction

endpackage

/* File: rtl/ethst_stat_counter.sv */
// one 16-bit statistics counter with load, alias writes and clear after read
`timescale 1ns/100ps
`include "ethst_regs.svh"
module ethst_stat_counter (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire ethst_pkg::ethst_cnt_cmd_t cmd,
    output logic [15:0]                    count
);
    logic [15:0] countReg;
    logic [15:0] countNext;

    wire [15:0] written = ethst_pkg::ethst_alias_apply(countReg, cmd.wdata, cmd.wmask, cmd.mode);
    // subtract what was read so an event caught between capture and clear is kept
    wire [15:0] drained = countReg - cmd.rdVal;
    wire [15:0] baseVal = cmd.wr ? written : (cmd.rdClr ? drained : countReg);
    // plain 16-bit add wraps from full to zero
    assign countNext = baseVal + {15'h0, cmd.inc};

    always_ff @(posedge clk) begin
        if (reset) begin
            countReg <= `ETHST_CNT_RST;
        end else begin
            countReg <= countNext;
        end
    end

    assign count = countReg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_count_step: assert property (cmd.inc && !cmd.wr && !cmd.rdClr |=> countReg == $past(countReg) + `ETHST_CNT_ONE)
        else $error("counter did not step by one");
    a_count_hold: assert property (!cmd.inc && !cmd.wr && !cmd.rdClr |=> $stable(countReg))
        else $error("counter moved without cause");
    a_read_clear: assert property (cmd.rdClr && !cmd.wr && !cmd.inc && cmd.rdVal == countReg
                                   |=> countReg == `ETHST_ZERO16)
        else $error("counter not cleared after read");
    a_direct_load: assert property (cmd.wr && cmd.mode == ethst_pkg::ALIAS_WRITE && cmd.wmask == 16'hFFFF && !cmd.inc
                                    |=> countReg == $past(cmd.wdata))
        else $error("counter did not load written value");
endmodule

/* File: rtl/ethst_avalon_slave.sv */
// avalon-mm slave front end: one wait cycle, registered read data, accept strobes
`timescale 1ns/100ps
module ethst_avalon_slave (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [7:0]            avs_address,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    input  wire logic [31:0]           rdMux,
    output logic                       avs_waitrequest,
    output logic [31:0]                avs_readdata,
    output ethst_pkg::ethst_bus_t      req
);
    ethst_pkg::ethst_slv_state_t stateReg;
    ethst_pkg::ethst_slv_state_t stateNext;
    logic [31:0]                 rdataReg;

    wire reqOn  = avs_read | avs_write;
    wire inIdle = stateReg == ethst_pkg::SLV_IDLE;

    always_comb begin
        case (stateReg)
            ethst_pkg::SLV_IDLE: stateNext = reqOn ? ethst_pkg::SLV_ACK : ethst_pkg::SLV_IDLE;
            ethst_pkg::SLV_ACK:  stateNext = ethst_pkg::SLV_IDLE;
            default:             stateNext = ethst_pkg::SLV_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stateReg <= ethst_pkg::SLV_IDLE;
            rdataReg <= 32'h00000000;
        end else begin
            stateReg <= stateNext;
            if (inIdle && avs_read) begin
                rdataReg <= rdMux;
            end
        end
    end

    assign avs_waitrequest = reqOn & inIdle;
    assign avs_readdata    = rdataReg;
    assign req.rd          = avs_read & !inIdle;
    assign req.wr          = avs_write & !inIdle;
    assign req.addr        = avs_address;
    assign req.wdata       = avs_writedata;
    assign req.be          = avs_byteenable;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence sWaiting;
        reqOn && avs_waitrequest;
    endsequence

    a_bus_answer: assert property (sWaiting |=> !avs_waitrequest)
        else $error("request not answered in one wait cycle");
endmodule

/* File: rtl/ethst_top.sv */
// status activity bits, module enable, overrun flag and three statistics counters behind avalon-mm
// Functional notes
// - The transmit-active bit 6 is high while a frame is being sent and low when transmit is idle.
// - The transmit-active bit may fall with no transmit-complete event, since the MAC may abort a frame.
// - The receive-active bit 5 is high while a frame is being received and low when receive is idle.
// - The receive-active bit may fall with no receive-complete event, since the filter may reject a frame.
// - Only transmit activity and the module enable move the transmit-active bit, and only receive activity and the module enable the receive-active bit.
// - Both activity bits are held low while the module-enable bit 15 of the first control register is 0.
// - Status bits 4..0 and counter bits 31..16 are unimplemented and read as zero.
// - The dropped-frame counter counts frames accepted by the filter and then lost to receive FIFO overrun.
// - That same overrun event sets the overrun flag at bit 0 of the interrupt request register.
// - The transmit-success counter counts each frame sent successfully.
// - The single-collision counter counts each frame sent successfully after exactly one collision.
// - Each counter clears after a read unless byte enables 0 and 1 of that read are both 0.
// - Module busy reads 1 while the module is enabled or still finishing a transaction.
`timescale 1ns/100ps
`include "ethst_regs.svh"
module ethst_top (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [7:0]  avs_address,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic             avs_waitrequest,
    output logic [31:0]      avs_readdata,
    input  wire logic        txBusyIn,
    input  wire logic        rxBusyIn,
    input  wire logic        txFrameOk,
    input  wire logic [3:0]  txCollisions,
    input  wire logic        rxFilterAccept,
    input  wire logic        rxFifoOverrun,
    output logic             moduleOn,
    output logic             rxFifoOverrunFlag,
    output logic             txActiveFlag,
    output logic             rxActiveFlag,
    output logic             moduleBusyFlag
);
    localparam logic [7:0] CNT_OFF [3] = '{`ETHST_OFF_RXOVF, `ETHST_OFF_TXOK, `ETHST_OFF_SCOL};

    logic                  onReg;
    logic                  onNext;
    logic                  ovfReg;
    logic                  ovfNext;
    logic                  txActReg;
    logic                  rxActReg;
    logic                  busyReg;
    logic [31:0]           rdMux;
    logic [15:0]           cntVal [3];
    ethst_pkg::ethst_bus_t req;

    function automatic logic regHit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:4] == off[7:4];
    endfunction

    ethst_avalon_slave uSlave (
        .clk             (clk),
        .reset           (reset),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_address     (avs_address),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .rdMux           (rdMux),
        .avs_waitrequest (avs_waitrequest),
        .avs_readdata    (avs_readdata),
        .req             (req)
    );

    // address decode
    wire                         rdBase   = avs_address[3:2] == 2'h0;
    wire                         reqBase  = req.addr[3:2] == 2'h0;
    wire ethst_pkg::ethst_alias_t wrMode  = ethst_pkg::ethst_alias_t'(req.addr[3:2]);
    wire [15:0]                  laneMask = {{8{req.be[1]}}, {8{req.be[0]}}};
    wire                         conWr    = req.wr & regHit(req.addr, `ETHST_OFF_CON1);
    wire                         irqWr    = req.wr & regHit(req.addr, `ETHST_OFF_IRQ);
    wire                         lowLanes = |req.be[1:0];

    // register images
    wire [15:0] conWord  = {onReg, 15'h0000};
    wire [15:0] irqWord  = {15'h0000, ovfReg};
    wire [31:0] statWord = {24'h000000, busyReg, txActReg, rxActReg, 5'h00};
    wire [15:0] conNew   = ethst_pkg::ethst_alias_apply(conWord, req.wdata[15:0], laneMask, wrMode);
    wire [15:0] irqNew   = ethst_pkg::ethst_alias_apply(irqWord, req.wdata[15:0], laneMask, wrMode);

    // datapath events
    wire rxDrop   = rxFilterAccept & rxFifoOverrun;
    wire txSingle = txFrameOk & (txCollisions == `ETHST_ONE_COLL);
    wire [2:0] incVec = {txSingle, txFrameOk, rxDrop};

    // read mux, aliases read as zero, upper half of counters zero
    assign rdMux = !rdBase ? 32'h00000000 :
                   regHit(avs_address, `ETHST_OFF_CON1)  ? {16'h0000, conWord} :
                   regHit(avs_address, `ETHST_OFF_IRQ)   ? {16'h0000, irqWord} :
                   regHit(avs_address, `ETHST_OFF_STAT)  ? statWord :
                   regHit(avs_address, `ETHST_OFF_RXOVF) ? {16'h0000, cntVal[0]} :
                   regHit(avs_address, `ETHST_OFF_TXOK)  ? {16'h0000, cntVal[1]} :
                   regHit(avs_address, `ETHST_OFF_SCOL)  ? {16'h0000, cntVal[2]} :
                   32'h00000000;

    assign onNext  = conWr ? conNew[`ETHST_BIT_ON] : onReg;
    // hardware set wins over a software clear in the same cycle
    assign ovfNext = rxDrop | (irqWr ? irqNew[`ETHST_BIT_OVF] : ovfReg);

    always_ff @(posedge clk) begin
        if (reset) begin
            onReg    <= 1'b0;
            ovfReg   <= 1'b0;
            txActReg <= 1'b0;
            rxActReg <= 1'b0;
            busyReg  <= 1'b0;
        end else begin
            onReg    <= onNext;
            ovfReg   <= ovfNext;
            // follows transmit activity gated by the module enable, no completion event needed to fall
            txActReg <= onReg & txBusyIn;
            rxActReg <= onReg & rxBusyIn;
            busyReg  <= onReg | txBusyIn | rxBusyIn;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : gCnt
            ethst_pkg::ethst_cnt_cmd_t cmd;
            wire hit = regHit(req.addr, CNT_OFF[i]);
            assign cmd.inc   = incVec[i];
            assign cmd.wr    = req.wr & hit;
            assign cmd.mode  = wrMode;
            assign cmd.wdata = req.wdata[15:0];
            assign cmd.wmask = laneMask;
            assign cmd.rdClr = req.rd & hit & reqBase & lowLanes;
            assign cmd.rdVal = avs_readdata[15:0];
            ethst_stat_counter uCnt (
                .clk   (clk),
                .reset (reset),
                .cmd   (cmd),
                .count (cntVal[i])
            );
        end
    endgenerate

    assign moduleOn          = onReg;
    assign rxFifoOverrunFlag = ovfReg;
    assign txActiveFlag      = txActReg;
    assign rxActiveFlag      = rxActReg;
    assign moduleBusyFlag    = busyReg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_tx_active_follow: assert property (##1 txActReg == $past(onReg & txBusyIn))
        else $error("tx active bit does not follow transmit activity");
    a_rx_active_follow: assert property (##1 rxActReg == $past(onReg & rxBusyIn))
        else $error("rx active bit does not follow receive activity");
    a_tx_fall_silent: assert property (onReg && txActReg && !txBusyIn && !conWr |=> !txActReg)
        else $error("tx active bit did not fall when transmit stopped");
    a_rx_fall_silent: assert property (onReg && rxActReg && !rxBusyIn && !conWr |=> !rxActReg)
        else $error("rx active bit did not fall when receive stopped");
    a_tx_only_tx: assert property (##2 $changed(txActReg) |-> $past(txBusyIn, 2) != $past(txBusyIn) ||
                                   $past(onReg, 2) != $past(onReg))
        else $error("tx active bit moved without transmit cause");
    a_off_forces_low: assert property (!onReg ##1 !onReg |-> !txActReg && !rxActReg)
        else $error("activity bit high while module disabled");
    a_reads_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000 &&
                                         (!regHit(avs_address, `ETHST_OFF_STAT) || avs_readdata[4:0] == 5'h00))
        else $error("unimplemented bits read nonzero");
    a_drop_sets_flag: assert property (rxDrop |=> ovfReg)
        else $error("overrun drop did not set flag");
    a_drop_counts: assert property (rxDrop && !gCnt[0].cmd.wr && !gCnt[0].cmd.rdClr
                                    |=> cntVal[0] == $past(cntVal[0]) + `ETHST_CNT_ONE)
        else $error("dropped frame not counted");
    a_single_counts: assert property (txFrameOk && txCollisions != `ETHST_ONE_COLL && !gCnt[2].cmd.wr &&
                                      !gCnt[2].cmd.rdClr |=> $stable(cntVal[2]))
        else $error("single collision count moved on wrong frame");
    a_busy_when_on: assert property (onReg |=> busyReg)
        else $error("busy low while module enabled");
    a_no_clear_lanes: assert property (req.rd && !lowLanes && !incVec[1] |=> $stable(cntVal[1]))
        else $error("counter cleared on read without low byte lanes");
endmodule

/* File: verification/ethst_top_test.sv */
// self-checking bench for the status activity bits and statistics counters
`timescale 1ns/100ps
`include "ethst_regs.svh"
module ethst_top_test;
    typedef struct {
        logic        ok;
        logic [3:0]  coll;
        logic        acc;
        logic        ovf;
        int          n;
        logic [15:0] eOvf;
        logic [15:0] eOk;
        logic [15:0] eScol;
    } ethst_row_t;

    logic        clk;
    logic        reset;
    logic        avsRead;
    logic        avsWrite;
    logic [7:0]  avsAddress;
    logic [31:0] avsWritedata;
    logic [3:0]  avsByteenable;
    logic        avsWaitrequest;
    logic [31:0] avsReaddata;
    logic        txBusyIn;
    logic        rxBusyIn;
    logic        txFrameOk;
    logic [3:0]  txCollisions;
    logic        rxFilterAccept;
    logic        rxFifoOverrun;
    logic        moduleOn;
    logic        rxFifoOverrunFlag;
    logic        txActiveFlag;
    logic        rxActiveFlag;
    logic        moduleBusyFlag;
    int          nFail;
    int          cmpCount;
    ethst_row_t  rows[6];

    ethst_top uut (.clk(clk), .reset(reset), .avs_read(avsRead), .avs_write(avsWrite), .avs_address(avsAddress),
        .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable), .avs_waitrequest(avsWaitrequest),
        .avs_readdata(avsReaddata), .txBusyIn(txBusyIn), .rxBusyIn(rxBusyIn), .txFrameOk(txFrameOk),
        .txCollisions(txCollisions), .rxFilterAccept(rxFilterAccept), .rxFifoOverrun(rxFifoOverrun),
        .moduleOn(moduleOn), .rxFifoOverrunFlag(rxFifoOverrunFlag), .txActiveFlag(txActiveFlag),
        .rxActiveFlag(rxActiveFlag), .moduleBusyFlag(moduleBusyFlag));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic closeOut();
        $display("comparisons %0d, mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmpCount++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        cmpCount++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic busXfer(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                           output logic [31:0] q);
        int i;
        @(posedge clk);
        avsRead <= rd;
        avsWrite <= !rd;
        avsAddress <= a;
        avsWritedata <= d;
        avsByteenable <= be;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (avsWaitrequest === 1'b0) break;
        end
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (i == 50) begin
            nFail++;
            $display("[FAIL] %0t bus answer timed out", $time);
            closeOut();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        busXfer(1'b0, a, d, 4'hF, q);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
        logic [31:0] q;
        busXfer(1'b1, a, 32'h00000000, be, q);
        chk32(q, exp, "read data");
    endtask

    task automatic pulses(input int n, input logic ok, input logic [3:0] coll, input logic acc, input logic ovf);
        repeat (n) begin
            @(posedge clk);
            txFrameOk <= ok;
            txCollisions <= coll;
            rxFilterAccept <= acc;
            rxFifoOverrun <= ovf;
            @(posedge clk);
            txFrameOk <= 1'b0;
            rxFifoOverrun <= 1'b0;
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        nFail = 0;
        cmpCount = 0;
        reset = 1'b1;
        {avsRead, avsWrite, avsAddress, avsWritedata, avsByteenable} = '0;
        {txBusyIn, rxBusyIn, txFrameOk, txCollisions, rxFilterAccept, rxFifoOverrun} = '0;
        rows[0] = '{1'b1, 4'h0, 1'b0, 1'b0, 3, 16'h0000, 16'h0003, 16'h0000};
        rows[1] = '{1'b1, 4'h1, 1'b0, 1'b0, 2, 16'h0000, 16'h0002, 16'h0002};
        rows[2] = '{1'b1, 4'h2, 1'b0, 1'b0, 1, 16'h0000, 16'h0001, 16'h0000};
        rows[3] = '{1'b0, 4'h1, 1'b0, 1'b0, 2, 16'h0000, 16'h0000, 16'h0000};
        rows[4] = '{1'b0, 4'h0, 1'b1, 1'b1, 2, 16'h0002, 16'h0000, 16'h0000};
        rows[5] = '{1'b0, 4'h0, 1'b0, 1'b1, 2, 16'h0000, 16'h0000, 16'h0000};
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[k]) begin
            pulses(rows[k].n, rows[k].ok, rows[k].coll, rows[k].acc, rows[k].ovf);
            rdChk(`ETHST_OFF_RXOVF, 4'hF, {16'h0000, rows[k].eOvf});
            rdChk(`ETHST_OFF_TXOK, 4'hF, {16'h0000, rows[k].eOk});
            rdChk(`ETHST_OFF_SCOL, 4'hF, {16'h0000, rows[k].eScol});
        end
        // transmit-success counter reads back as cleared after the reads above
        rdChk(`ETHST_OFF_TXOK, 4'hF, 32'h00000000);
        rdChk(`ETHST_OFF_STAT, 4'hF, 32'h00000000);
        rdChk(8'hF0, 4'hF, 32'h00000000);
        // activity bits follow only their own side
        wr(`ETHST_OFF_CON1, 32'h00008000);
        rdChk(`ETHST_OFF_STAT, 4'hF, 32'h00000080);
        @(posedge clk) txBusyIn <= 1'b1;
        settle();
        chk1(txActiveFlag, 1'b1, "tx active");
        chk1(rxActiveFlag, 1'b0, "rx active");
        rdChk(`ETHST_OFF_STAT, 4'hF, 32'h000000C0);
        @(posedge clk) rxBusyIn <= 1'b1;
        settle();
        chk1(rxActiveFlag, 1'b1, "rx active");
        rdChk(`ETHST_OFF_STAT, 4'hF, 32'h000000E0);
        @(posedge clk) txBusyIn <= 1'b0;
        settle();
        chk1(txActiveFlag, 1'b0, "tx active after abort");
        chk1(rxActiveFlag, 1'b1, "rx active");
        @(posedge clk) rxBusyIn <= 1'b0;
        settle();
        chk1(rxActiveFlag, 1'b0, "rx active after reject");
        @(posedge clk) {txBusyIn, rxBusyIn} <= 2'b11;
        wr(`ETHST_OFF_CON1, 32'h00000000);
        settle();
        chk1(moduleOn, 1'b0, "module enable");
        chk1(txActiveFlag, 1'b0, "tx active when off");
        chk1(rxActiveFlag, 1'b0, "rx active when off");
        chk1(moduleBusyFlag, 1'b1, "busy finishing");
        @(posedge clk) {txBusyIn, rxBusyIn} <= 2'b00;
        settle();
        chk1(moduleBusyFlag, 1'b0, "busy idle");
        // overrun flag set by the counted event, cleared by the clear alias
        wr(`ETHST_OFF_IRQ + 8'h04, 32'h00000001);
        settle();
        chk1(rxFifoOverrunFlag, 1'b0, "overrun flag cleared");
        pulses(1, 1'b0, 4'h0, 1'b1, 1'b1);
        settle();
        chk1(rxFifoOverrunFlag, 1'b1, "overrun flag set");
        rdChk(`ETHST_OFF_IRQ, 4'hF, 32'h00000001);
        rdChk(`ETHST_OFF_RXOVF, 4'hF, 32'h00000001);
        // read with low byte enables off keeps the count
        pulses(2, 1'b1, 4'h0, 1'b0, 1'b0);
        rdChk(`ETHST_OFF_TXOK, 4'hC, 32'h00000002);
        rdChk(`ETHST_OFF_TXOK, 4'h1, 32'h00000002);
        rdChk(`ETHST_OFF_TXOK, 4'hF, 32'h00000000);
        // direct load, upper bits dropped, wrap at maximum
        wr(`ETHST_OFF_TXOK, 32'hABCD1234);
        rdChk(`ETHST_OFF_TXOK, 4'hF, 32'h00001234);
        wr(`ETHST_OFF_SCOL, 32'h0000FFFF);
        pulses(1, 1'b1, 4'h1, 1'b0, 1'b0);
        rdChk(`ETHST_OFF_SCOL, 4'hF, 32'h00000000);
        rdChk(`ETHST_OFF_TXOK, 4'hF, 32'h00000001);
        closeOut();
    end
endmodule
